// ===== mirror_bit_cell.sv
// mirror_bit_cell: enable and load-arm storage for one pwm module slot
// assumes all strobes come from logic on aclk
`timescale 1ns/1ns
`default_nettype none
module mirror_bit_cell
	import pwm_mirror_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// software side
	input  wire logic sw_enable_wr,
	input  wire logic sw_enable_data,
	input  wire logic sw_load_wr,
	input  wire logic sw_load_data,
	// module side
	input  wire logic hw_enable_wr,
	input  wire logic hw_enable_data,
	input  wire logic hw_load_wr,
	input  wire logic hw_load_data,
	input  wire logic load_taken,
	output logic      enable_bit,
	output logic      load_arm_bit
);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			enable_bit <= mirror_reset[0];
		else if (sw_enable_wr)
			enable_bit <= sw_enable_data;
		else if (hw_enable_wr)
			enable_bit <= hw_enable_data;
	end

	// load arm storage
	// a software arm in the same cycle as a completed load is kept
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			load_arm_bit <= mirror_reset[0];
		else if (sw_load_wr)
			load_arm_bit <= sw_load_data;
		else if (hw_load_wr)
			load_arm_bit <= hw_load_data;
		else if (load_taken)
			load_arm_bit <= 1'b0;
	end

endmodule : mirror_bit_cell
`default_nettype wire

// ===== pwm_bit_mirror_registers.sv
// pwm_bit_mirror_registers: three mirror registers gathering one bit from each pwm module
// assumes modules sit on aclk and use enable_bit / load_arm_bit as their own control bits
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pwm_bit_mirror_registers
	import pwm_mirror_pkg::*;
#(
	parameter bit has_module12 = 1'b1
)
(
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite write address
	input  wire logic [addr_width-1:0]   awaddr,
	input  wire logic [2:0]              awprot,
	input  wire logic                    awvalid,
	output logic                         awready,
	// axi4-lite write data
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	// axi4-lite write response
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	// axi4-lite read address
	input  wire logic [addr_width-1:0]   araddr,
	input  wire logic [2:0]              arprot,
	input  wire logic                    arvalid,
	output logic                         arready,
	// axi4-lite read data
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	// module control bits, index 0..3 = module 5, 6, 11, 12
	output logic [slot_count-1:0]        enable_bit,
	output logic [slot_count-1:0]        load_arm_bit,
	input  wire logic [slot_count-1:0]   output_state,
	output logic [slot_count-1:0]        output_write,
	output logic [slot_count-1:0]        output_wdata,
	// writes from the modules' own control registers
	input  wire logic [slot_count-1:0]   module_enable_wr,
	input  wire logic [slot_count-1:0]   module_enable_wdata,
	input  wire logic [slot_count-1:0]   module_load_wr,
	input  wire logic [slot_count-1:0]   module_load_wdata,
	input  wire logic [slot_count-1:0]   load_taken
);

	// ----------------------------------------------------------------
	// write channel capture
	// ----------------------------------------------------------------
	logic                  aw_held_reg;
	logic [addr_width-1:0] aw_addr_reg;
	logic                  w_held_reg;
	logic [7:0]            w_data_reg;
	logic                  w_lane0_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  do_write;
	reg_sel_type           wsel;
	logic [slot_count-1:0] slot_mask;

	assign awready  = !aw_held_reg && !bvalid_reg;
	assign wready   = !w_held_reg && !bvalid_reg;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wsel     = decode_addr(aw_addr_reg);
	assign bvalid   = bvalid_reg;
	assign bresp    = bresp_reg;

	// module 12 slot exists only when fitted
	assign slot_mask = {has_module12, 3'h7};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end
		else if (awvalid && awready)
		begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= awaddr;
		end
		else if (do_write)
			aw_held_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_reg  <= 1'b0;
			w_data_reg  <= mirror_reset;
			w_lane0_reg <= 1'b0;
		end
		else if (wvalid && wready)
		begin
			w_held_reg  <= 1'b1;
			w_data_reg  <= wdata[7:0];
			w_lane0_reg <= wstrb[0];
		end
		else if (do_write)
			w_held_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= resp_okay;
		end
		else if (do_write)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (wsel == sel_none) ? resp_slverr : resp_okay;
		end
		else if (bready)
			bvalid_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// per-module storage
	// ----------------------------------------------------------------
	logic sw_en_wr;
	logic sw_ld_wr;

	// one strobe reaches all slots at once
	assign sw_en_wr = do_write && w_lane0_reg && (wsel == sel_enable);
	assign sw_ld_wr = do_write && w_lane0_reg && (wsel == sel_load);

	genvar i;
	generate
		for (i = 0; i < slot_count; i++)
		begin : g_slot
			if (i < 3 || has_module12)
			begin : g_cell
				mirror_bit_cell u_cell (
					.aclk           (aclk),
					.aresetn        (aresetn),
					.sw_enable_wr   (sw_en_wr),
					.sw_enable_data (w_data_reg[i]),
					.sw_load_wr     (sw_ld_wr),
					.sw_load_data   (w_data_reg[i]),
					.hw_enable_wr   (module_enable_wr[i]),
					.hw_enable_data (module_enable_wdata[i]),
					.hw_load_wr     (module_load_wr[i]),
					.hw_load_data   (module_load_wdata[i]),
					.load_taken     (load_taken[i]),
					.enable_bit     (enable_bit[i]),
					.load_arm_bit   (load_arm_bit[i])
				);
			end
			else
			begin : g_absent
				assign enable_bit[i]   = 1'b0;
				assign load_arm_bit[i] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// output state writes
	// ----------------------------------------------------------------
	// output writes pass to the modules as a one-cycle strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			output_write <= '0;
			output_wdata <= '0;
		end
		else if (do_write && w_lane0_reg && (wsel == sel_output))
		begin
			output_write <= slot_mask;
			output_wdata <= w_data_reg[slot_count-1:0] & slot_mask;
		end
		else
			output_write <= '0;
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [3:0]  rd_bits;
	reg_sel_type rsel;

	assign arready = !rvalid_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;
	assign rsel    = decode_addr(araddr);

	// bit order and zero upper bits
	always_comb
	begin
		unique case (rsel)
			sel_enable: rd_bits = enable_bit & slot_mask;
			sel_load:   rd_bits = load_arm_bit & slot_mask;
			sel_output: rd_bits = output_state & slot_mask;
			sel_none:   rd_bits = 4'h0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= resp_okay;
		end
		else if (arvalid && arready)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {28'h000_0000, rd_bits};
			rresp_reg  <= (rsel == sel_none) ? resp_slverr : resp_okay;
		end
		else if (rready)
			rvalid_reg <= 1'b0;
	end

endmodule : pwm_bit_mirror_registers
`default_nettype wire

// ===== pwm_bit_mirror_registers_bench.sv
// pwm_bit_mirror_registers_bench: register traffic against the mirror bank
// assumes the slot model as the pwm modules; reads are checked from a queue
`timescale 1ns/1ns
`default_nettype none
module pwm_bit_mirror_registers_bench
	import pwm_mirror_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, seed = 32'hf57e, rdata;
	logic [3:0]  wstrb = 4'hf, finish_load = 4'h0;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [3:0]  enable_bit, load_arm_bit, output_state, output_write, output_wdata, load_taken;
	logic [3:0]  module_enable_wr = 4'h0, module_enable_wdata = 4'h0;
	logic [3:0]  module_load_wr = 4'h0, module_load_wdata = 4'h0;
	logic [33:0] exp_q[$];
	logic [1:0]  bexp_q[$];
	int          err_total = 0, num_checks = 0, cycles = 0;
	pwm_bit_mirror_registers #(.has_module12(1'b1)) pwm_bit_mirror_registers_i (.aclk, .aresetn,
		.awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.enable_bit, .load_arm_bit, .output_state, .output_write, .output_wdata, .module_enable_wr,
		.module_enable_wdata, .module_load_wr, .module_load_wdata, .load_taken);
	pwm_slot_model pwm_slot_model_i (.aclk, .aresetn, .output_write, .output_wdata,
		.load_arm_bit, .output_state, .load_taken, .finish_load);
	always #10 aclk = ~aclk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// random upper data bits must be ignored by the bank
	task automatic wr(input logic [11:0] a, input logic [3:0] v, input logic [1:0] er);
		logic [31:0] r;
		logic        ta, tw;
		r = rnd();
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {r[31:4], v};
		awprot <= r[2:0];
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bexp_q.push_back(er);
		while (!(ta && tw))
		begin
			@(negedge aclk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			@(posedge aclk);
			awvalid <= awvalid & ~ta;
			wvalid <= wvalid & ~tw;
		end
		do @(negedge aclk); while (!bvalid);
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		@(posedge aclk);
		araddr <= a;
		arprot <= 3'(rnd() >> 29);
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_q.push_back(e);
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	always @(negedge aclk)
		if (rvalid && rready)
			chk("read", exp_q.pop_front(), {rresp, rdata});
	always @(negedge aclk)
		if (bvalid && bready)
			chk("bresp", 34'(bexp_q.pop_front()), 34'(bresp));
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 3; i++)
			rd(12'(i << 2), 34'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(enable_mirror_off, 4'h1 << i, resp_okay);
			rd(enable_mirror_off, 34'h1 << i);
		end
		wr(enable_mirror_off, 4'hf, resp_okay);
		wr(load_mirror_off, 4'h7, resp_okay);
		chk("enable_bit", 34'hf, 34'(enable_bit));
		@(posedge aclk);
		finish_load <= 4'h5;
		@(posedge aclk);
		finish_load <= 4'h0;
		rd(load_mirror_off, 34'h2);
		@(posedge aclk);
		module_enable_wr <= 4'h4;
		module_load_wr <= 4'h1;
		module_load_wdata <= 4'h1;
		@(posedge aclk);
		module_enable_wr <= 4'h0;
		module_load_wr <= 4'h0;
		rd(enable_mirror_off, 34'hb);
		rd(load_mirror_off, 34'h3);
		// lane 0 strobe off: the write is answered but changes nothing
		wstrb <= 4'he;
		wr(enable_mirror_off, 4'h0, resp_okay);
		wstrb <= 4'hf;
		rd(enable_mirror_off, 34'hb);
		wr(output_mirror_off, 4'ha, resp_okay);
		rd(output_mirror_off, 34'ha);
		wr(12'h00c, 4'h1, resp_slverr);
		rd(12'h010, {resp_slverr, 32'h0});
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 3; i++)
			rd(12'(i << 2), 34'h0);
		summarize();
	end
endmodule : pwm_bit_mirror_registers_bench
`default_nettype wire

// ===== pwm_bit_mirror_registers_props.sv
// pwm_mirror_props: bus and mirror timing of the bank
// assumes the bench keeps the write address and data together
`timescale 1ns/1ns
`default_nettype none
module pwm_mirror_props
	import pwm_mirror_pkg::*;
#(
	parameter bit has_module12 = 1'b1
)
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [addr_width-1:0] awaddr,
	input wire logic                  awvalid,
	input wire logic                  awready,
	input wire logic [31:0]           wdata,
	input wire logic [3:0]            wstrb,
	input wire logic                  wvalid,
	input wire logic                  wready,
	input wire logic [1:0]            bresp,
	input wire logic                  bvalid,
	input wire logic                  bready,
	input wire logic                  arvalid,
	input wire logic                  arready,
	input wire logic [31:0]           rdata,
	input wire logic                  rvalid,
	input wire logic                  rready,
	input wire logic [3:0]            enable_bit,
	input wire logic [3:0]            load_arm_bit,
	input wire logic [3:0]            output_write
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_hs;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence wr_at(logic [11:0] off);
		wr_hs ##0 (wstrb[0] && {awaddr[11:2], 2'h0} == off);
	endsequence
	a_enable_write: assert property (wr_at(enable_mirror_off) |-> ##2
		enable_bit == ($past(wdata[3:0], 2) & {has_module12, 3'h7})) else $error("enable bits");
	a_load_write: assert property (wr_at(load_mirror_off) |-> ##2
		load_arm_bit == ($past(wdata[3:0], 2) & {has_module12, 3'h7})) else $error("load bits");
	a_output_pulse: assert property (wr_at(output_mirror_off) |-> ##2
		output_write == {has_module12, 3'h7}) else $error("output pulse");
	a_rdata_upper: assert property (rvalid |-> rdata[31:4] == 28'h0)
		else $error("upper read bits");
	a_reset_clear: assert property ($rose(aresetn) |->
		enable_bit == 4'h0 && load_arm_bit == 4'h0) else $error("reset value");
	a_write_slverr: assert property ((wr_hs ##0 awaddr[11:2] > 10'h2) |-> ##2
		bvalid && bresp == resp_slverr) else $error("unmapped write");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read latency");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data");
endmodule : pwm_mirror_props
bind pwm_bit_mirror_registers pwm_mirror_props #(.has_module12(has_module12)) pwm_mirror_props_i (
	.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
	.bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .enable_bit, .load_arm_bit,
	.output_write);
`default_nettype wire

// ===== pwm_mirror_pkg.sv
// pwm_mirror_pkg: offsets, widths and reset values of the pwm bit mirror bank
// assumes a 32-bit axi4-lite register bus with 12-bit byte addresses
package pwm_mirror_pkg;

	localparam int          addr_width        = 12;
	localparam int          slot_count        = 4;
	localparam int          mirror_width      = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] enable_mirror_off = 12'h000;
	localparam logic [11:0] load_mirror_off   = 12'h004;
	localparam logic [11:0] output_mirror_off = 12'h008;

	localparam logic [7:0]  mirror_reset      = 8'h00;

	localparam logic [1:0]  resp_okay         = 2'h0;
	localparam logic [1:0]  resp_slverr       = 2'h2;

	typedef enum logic [1:0] {
		sel_none   = 2'h0,
		sel_enable = 2'h1,
		sel_load   = 2'h3,
		sel_output = 2'h2
	} reg_sel_type;

	// word address decode shared by the read and write paths
	function automatic reg_sel_type decode_addr(input logic [11:0] addr);
		reg_sel_type sel;
		sel = sel_none;
		if ({addr[11:2], 2'h0} == enable_mirror_off)
			sel = sel_enable;
		else if ({addr[11:2], 2'h0} == load_mirror_off)
			sel = sel_load;
		else if ({addr[11:2], 2'h0} == output_mirror_off)
			sel = sel_output;
		return sel;
	endfunction : decode_addr

endpackage : pwm_mirror_pkg

// ===== pwm_slot_model.sv
// pwm_slot_model: the four pwm modules behind the mirror bank
// assumes aclk and synchronous active-low aresetn shared with the bank
`timescale 1ns/1ns
`default_nettype none
module pwm_slot_model
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// bank side
	input  wire logic [3:0] output_write,
	input  wire logic [3:0] output_wdata,
	input  wire logic [3:0] load_arm_bit,
	output logic      [3:0] output_state,
	output logic      [3:0] load_taken,
	// bench command: which modules finish a load
	input  wire logic [3:0] finish_load
);
	always_ff @(posedge aclk)
		if (!aresetn)
			output_state <= 4'h0;
		else
			output_state <= (output_state & ~output_write) | (output_wdata & output_write);
	always_ff @(posedge aclk)
		if (!aresetn)
			load_taken <= 4'h0;
		else
			load_taken <= finish_load & load_arm_bit;
endmodule : pwm_slot_model
`default_nettype wire
